// file: hdl/isp_read_prepare_handler.sv
/*
 * Read-memory and sector-prepare command handler with UU-encoded read stream.
 * Assumes UART bytes and memory are on i_ref_clk; memory data must be valid in the same cycle as the read strobe.
 */
`timescale 1ns/1ps
`include "isp_regs.svh"

module isp_read_prepare_handler #(
	parameter int          NSECT       = 8,
	parameter logic [31:0] FLASH_BASE  = 32'h0000_0000,
	parameter logic [31:0] FLASH_BYTES = 32'h0000_8000,
	parameter logic [31:0] RAM_BASE    = 32'h1000_0000,
	parameter logic [31:0] RAM_BYTES   = 32'h0000_2000,
	parameter logic [NSECT-1:0] BOOT_MASK = {1'b1, {(NSECT-1){1'b0}}}
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_reset_n,
	input  wire isp_pkg::byte_t    i_rx,
	output isp_pkg::byte_t         o_tx,
	input  wire logic              i_tx_ready,
	output isp_pkg::mem_req_t      o_mem,
	input  wire logic [7:0]        i_mem_rdata,
	input  wire logic              i_crp_active,
	input  wire isp_pkg::op_req_t  i_op,
	input  wire logic              i_op_done,
	output logic                   o_op_permit,
	output logic [NSECT-1:0]       o_sector_prepared
);

	// ==========================================
	// State
	isp_pkg::state_t   st_q, st_d;
	isp_pkg::parse_t   par_q, par_d;
	isp_pkg::xfer_t    xf_q, xf_d;
	isp_pkg::dec_t     dec_q, dec_d;
	isp_pkg::byte_t    tx_q, tx_d;
	isp_pkg::mem_req_t mem_q, mem_d;
	logic [3:0]        code_q, code_d;
	logic              go_q, go_d;
	logic [NSECT-1:0]  prep_q, prep_d;

	logic              line_done;
	logic              tx_free;
	logic [2:0]        nparams;
	logic [NSECT-1:0]  prange;
	logic [NSECT-1:0]  orange;
	logic [NSECT-1:0]  setmask;
	logic [32:0]       rd_end;
	logic              mapped;
	logic [5:0]        six;
	logic [5:0]        nline;
	logic [3:0]        rc;
	logic [`ISP_SUM_W-1:0] pw;

	function automatic logic [`ISP_SUM_W-1:0] pow10(input logic [2:0] p);
		case (p)
			3'h0: pow10 = `ISP_SUM_W'(1);
			3'h1: pow10 = `ISP_SUM_W'(10);
			3'h2: pow10 = `ISP_SUM_W'(100);
			3'h3: pow10 = `ISP_SUM_W'(1000);
			3'h4: pow10 = `ISP_SUM_W'(10000);
			default: pow10 = `ISP_SUM_W'(100000);
		endcase
	endfunction : pow10

	assign o_tx              = tx_q;
	assign o_mem             = mem_q;
	assign o_sector_prepared = prep_q;
	assign tx_free           = !tx_q.valid || i_tx_ready;
	assign nparams           = {1'b0, par_q.pidx} + {2'b00, par_q.innum};

	// ==========================================
	// Range decoding
	always_comb begin
		for (int i = 0; i < NSECT; i++) begin
			prange[i] = (32'(i) >= par_q.p0) && (32'(i) <= par_q.p1);
			orange[i] = (8'(i) >= i_op.first) && (8'(i) <= i_op.last);
		end
		// Whole range must sit in one region; 33 bits keep the end from wrapping
		rd_end = {1'b0, par_q.p0} + {1'b0, par_q.p1};
		mapped = ((par_q.p0 >= FLASH_BASE) && (rd_end <= {1'b0, FLASH_BASE} + {1'b0, FLASH_BYTES}))
		      || ((par_q.p0 >= RAM_BASE) && (rd_end <= {1'b0, RAM_BASE} + {1'b0, RAM_BYTES}));
		o_op_permit = i_op.req && (i_op.last >= i_op.first)
		           && (32'(i_op.last) < 32'(NSECT))
		           && ((orange & ~prep_q) == '0);
	end

	// ==========================================
	// Next state
	always_comb begin
		st_d      = st_q;
		par_d     = par_q;
		xf_d      = xf_q;
		dec_d     = dec_q;
		tx_d      = tx_q;
		code_d    = code_q;
		go_d      = go_q;
		mem_d     = '{rd: 1'b0, addr: mem_q.addr};
		setmask   = '0;
		line_done = 1'b0;
		rc        = `ISP_RC_SUCCESS;
		six       = 6'h00;
		pw        = pow10(dec_q.pos);
		nline     = (xf_q.remain < 32'(`ISP_LINE_BYTES)) ? xf_q.remain[5:0] : `ISP_LINE_BYTES;
		if (tx_q.valid && i_tx_ready) begin
			tx_d.valid = 1'b0;
		end

		// Input is only listened to while idle or while an answer is awaited from the host
		if (i_rx.valid && (st_q == isp_pkg::S_IDLE || st_q == isp_pkg::S_WAIT)) begin
			if (i_rx.data == `ISP_LF) begin
				line_done     = par_q.prev_cr;
				par_d.first   = 1'b1;
				par_d.prev_cr = 1'b0;
				par_d.innum   = 1'b0;
				par_d.bad     = 1'b0;
				par_d.pidx    = 2'h0;
			end else if (i_rx.data == `ISP_CR) begin
				par_d.prev_cr = 1'b1;
			end else begin
				par_d.prev_cr = 1'b0;
				if (par_q.first) begin
					par_d.first = 1'b0;
					par_d.cmd   = i_rx.data;
					par_d.p0    = 32'h0;
					par_d.p1    = 32'h0;
				end else if (i_rx.data == `ISP_SP) begin
					if (par_q.innum) begin
						par_d.pidx  = par_q.pidx + 2'h1;
						par_d.innum = 1'b0;
					end
				end else if (i_rx.data >= `ISP_ZERO && i_rx.data <= `ISP_NINE
				             && par_q.pidx < 2'h2) begin
					par_d.innum = 1'b1;
					if (par_q.pidx == 2'h0) begin
						par_d.p0 = (par_q.p0 << 3) + (par_q.p0 << 1)
						         + {28'h0, i_rx.data[3:0]};
					end else begin
						par_d.p1 = (par_q.p1 << 3) + (par_q.p1 << 1)
						         + {28'h0, i_rx.data[3:0]};
					end
				end else begin
					par_d.bad = 1'b1;
				end
			end
		end

		case (st_q)
			isp_pkg::S_IDLE: begin
				if (line_done && par_q.cmd == `ISP_CMD_READ) begin
					if (i_crp_active) begin
						rc = `ISP_RC_CRP;
					end else if (par_q.bad || nparams != 3'h2) begin
						rc = `ISP_RC_PARAM;
					end else if (par_q.p0[1:0] != 2'h0) begin
						rc = `ISP_RC_ADDR;
					end else if (par_q.p1[1:0] != 2'h0) begin
						rc = `ISP_RC_COUNT;
					end else if (!mapped) begin
						rc = `ISP_RC_UNMAPPED;
					end
					code_d          = rc;
					go_d            = (rc == `ISP_RC_SUCCESS) && (par_q.p1 != 32'h0);
					xf_d.addr       = par_q.p0;
					xf_d.remain     = par_q.p1;
					xf_d.grp_addr   = par_q.p0;
					xf_d.grp_remain = par_q.p1;
					xf_d.sum        = '0;
					xf_d.lines      = 5'h0;
					st_d            = isp_pkg::S_CODE;
				end else if (line_done && par_q.cmd == `ISP_CMD_PREP) begin
					if (par_q.bad || nparams != 3'h2) begin
						rc = `ISP_RC_PARAM;
					end else if (par_q.p1 < par_q.p0 || par_q.p1 >= 32'(NSECT)) begin
						rc = `ISP_RC_INV_SECT;
					end else if ((prange & BOOT_MASK) != '0) begin
						rc = `ISP_RC_INV_SECT;
					end else begin
						setmask = prange;
					end
					code_d = rc;
					go_d   = 1'b0;
					st_d   = isp_pkg::S_CODE;
				end
			end
			isp_pkg::S_CODE: begin
				if (tx_free) begin
					tx_d = '{valid: 1'b1, data: `ISP_ZERO + {4'h0, code_q}};
					st_d = isp_pkg::S_CODE_CR;
				end
			end
			isp_pkg::S_CODE_CR: begin
				if (tx_free) begin
					tx_d = '{valid: 1'b1, data: `ISP_CR};
					st_d = isp_pkg::S_CODE_LF;
				end
			end
			isp_pkg::S_CODE_LF: begin
				if (tx_free) begin
					tx_d = '{valid: 1'b1, data: `ISP_LF};
					st_d = go_q ? isp_pkg::S_LLEN : isp_pkg::S_IDLE;
				end
			end
			isp_pkg::S_LLEN: begin
				if (tx_free) begin
					tx_d      = '{valid: 1'b1, data: `ISP_UU_BIAS + {2'b00, nline}};
					xf_d.left = nline;
					xf_d.bcnt = 2'h0;
					st_d      = isp_pkg::S_FETCH;
				end
			end
			isp_pkg::S_FETCH: begin
				if (xf_q.left == 6'h0) begin
					// Short tail of a line is padded with zero bytes, not summed
					xf_d.grp3 = {xf_q.grp3[15:0], 8'h00};
					xf_d.bcnt = xf_q.bcnt + 2'h1;
					if (xf_q.bcnt == 2'h2) begin
						xf_d.chidx = 2'h0;
						st_d       = isp_pkg::S_ENC;
					end
				end else begin
					mem_d = '{rd: 1'b1, addr: xf_q.addr};
					st_d  = isp_pkg::S_CAP;
				end
			end
			isp_pkg::S_CAP: begin
				xf_d.grp3   = {xf_q.grp3[15:0], i_mem_rdata};
				xf_d.sum    = xf_q.sum + {{(`ISP_SUM_W-8){1'b0}}, i_mem_rdata};
				xf_d.addr   = xf_q.addr + 32'h1;
				xf_d.remain = xf_q.remain - 32'h1;
				xf_d.left   = xf_q.left - 6'h1;
				xf_d.bcnt   = xf_q.bcnt + 2'h1;
				xf_d.chidx  = 2'h0;
				st_d        = (xf_q.bcnt == 2'h2) ? isp_pkg::S_ENC : isp_pkg::S_FETCH;
			end
			isp_pkg::S_ENC: begin
				case (xf_q.chidx)
					2'h0: six = xf_q.grp3[23:18];
					2'h1: six = xf_q.grp3[17:12];
					2'h2: six = xf_q.grp3[11:6];
					default: six = xf_q.grp3[5:0];
				endcase
				if (tx_free) begin
					tx_d       = '{valid: 1'b1, data: `ISP_UU_BIAS + {2'b00, six}};
					xf_d.chidx = xf_q.chidx + 2'h1;
					if (xf_q.chidx == 2'h3) begin
						xf_d.bcnt = 2'h0;
						st_d      = (xf_q.left == 6'h0) ? isp_pkg::S_LCR : isp_pkg::S_FETCH;
					end
				end
			end
			isp_pkg::S_LCR: begin
				if (tx_free) begin
					tx_d = '{valid: 1'b1, data: `ISP_CR};
					st_d = isp_pkg::S_LLF;
				end
			end
			isp_pkg::S_LLF: begin
				if (tx_free) begin
					tx_d       = '{valid: 1'b1, data: `ISP_LF};
					xf_d.lines = xf_q.lines + 5'h1;
					if (xf_q.lines == `ISP_GROUP_LINES - 5'h1
					    || xf_q.remain == 32'h0) begin
						dec_d = '{val: xf_q.sum, pos: `ISP_SUM_DIGITS, dig: 4'h0, started: 1'b0};
						st_d  = isp_pkg::S_SUM_DIG;
					end else begin
						st_d = isp_pkg::S_LLEN;
					end
				end
			end
			isp_pkg::S_SUM_DIG: begin
				// Digits by repeated subtraction: slow, but no divider
				if (dec_q.val >= pw) begin
					dec_d.val = dec_q.val - pw;
					dec_d.dig = dec_q.dig + 4'h1;
				end else if (tx_free) begin
					if (dec_q.dig != 4'h0 || dec_q.started || dec_q.pos == 3'h0) begin
						tx_d          = '{valid: 1'b1, data: `ISP_ZERO + {4'h0, dec_q.dig}};
						dec_d.started = 1'b1;
					end
					dec_d.dig = 4'h0;
					dec_d.pos = dec_q.pos - 3'h1;
					if (dec_q.pos == 3'h0) begin
						st_d = isp_pkg::S_SUM_CR;
					end
				end
			end
			isp_pkg::S_SUM_CR: begin
				if (tx_free) begin
					tx_d = '{valid: 1'b1, data: `ISP_CR};
					st_d = isp_pkg::S_SUM_LF;
				end
			end
			isp_pkg::S_SUM_LF: begin
				if (tx_free) begin
					tx_d = '{valid: 1'b1, data: `ISP_LF};
					st_d = isp_pkg::S_WAIT;
				end
			end
			isp_pkg::S_WAIT: begin
				if (line_done && par_q.cmd == `ISP_RPL_OK) begin
					xf_d.grp_addr   = xf_q.addr;
					xf_d.grp_remain = xf_q.remain;
					xf_d.sum        = '0;
					xf_d.lines      = 5'h0;
					st_d = (xf_q.remain == 32'h0) ? isp_pkg::S_IDLE : isp_pkg::S_LLEN;
				end else if (line_done && par_q.cmd == `ISP_RPL_RESEND) begin
					xf_d.addr   = xf_q.grp_addr;
					xf_d.remain = xf_q.grp_remain;
					xf_d.sum    = '0;
					xf_d.lines  = 5'h0;
					st_d        = isp_pkg::S_LLEN;
				end
			end
			default: st_d = isp_pkg::S_IDLE;
		endcase

		// Clear before set, so a prepare in the same cycle as a completion sticks
		prep_d = (prep_q & ~(i_op_done ? orange : '0)) | setmask;
	end

	// ==========================================
	// Registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			st_q   <= isp_pkg::S_IDLE;
			par_q  <= '{first: 1'b1, default: '0};
			xf_q   <= '0;
			dec_q  <= '0;
			tx_q   <= '0;
			mem_q  <= '0;
			code_q <= 4'h0;
			go_q   <= 1'b0;
			prep_q <= '0;
		end else begin
			st_q   <= st_d;
			par_q  <= par_d;
			xf_q   <= xf_d;
			dec_q  <= dec_d;
			tx_q   <= tx_d;
			mem_q  <= mem_d;
			code_q <= code_d;
			go_q   <= go_d;
			prep_q <= prep_d;
		end
	end

endmodule : isp_read_prepare_handler

// file: hdl/isp_regs.svh
/*
 * Constants for the in-system-programming read and prepare command handler.
 * Assumes ASCII command lines arriving byte by byte on the handler clock.
 */
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH

// ==========================================
// Characters
`define ISP_CR          8'h0d
`define ISP_LF          8'h0a
`define ISP_SP          8'h20
`define ISP_ZERO        8'h30
`define ISP_NINE        8'h39
`define ISP_CMD_READ    8'h52
`define ISP_CMD_PREP    8'h50
`define ISP_RPL_OK      8'h4f
`define ISP_RPL_RESEND  8'h52
`define ISP_UU_BIAS     8'h20

// ==========================================
// Answer codes, sent as one decimal digit
`define ISP_RC_SUCCESS  4'h0
`define ISP_RC_INV_SECT 4'h1
`define ISP_RC_PARAM    4'h2
`define ISP_RC_ADDR     4'h3
`define ISP_RC_UNMAPPED 4'h4
`define ISP_RC_COUNT    4'h5
`define ISP_RC_CRP      4'h6

// ==========================================
// Transfer framing
`define ISP_LINE_BYTES  6'h2d
`define ISP_GROUP_LINES 5'h14
`define ISP_SUM_W       18
`define ISP_SUM_DIGITS  3'h5

`endif

// file: hdl/isp_pkg.sv
/*
 * Types shared by the command handler and its surroundings.
 * Assumes sector numbers fit in eight bits.
 */
`include "isp_regs.svh"

package isp_pkg;

	// ==========================================
	// Handler states
	typedef enum logic [3:0] {
		S_IDLE, S_CODE, S_CODE_CR, S_CODE_LF, S_LLEN, S_FETCH, S_CAP, S_ENC,
		S_LCR, S_LLF, S_SUM_DIG, S_SUM_CR, S_SUM_LF, S_WAIT
	} state_t;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic        valid;
		logic [7:0]  data;
	} byte_t;

	typedef struct packed {
		logic        rd;
		logic [31:0] addr;
	} mem_req_t;

	typedef struct packed {
		logic        req;
		logic [7:0]  first;
		logic [7:0]  last;
	} op_req_t;

	typedef struct packed {
		logic        first;
		logic        prev_cr;
		logic        innum;
		logic        bad;
		logic [1:0]  pidx;
		logic [7:0]  cmd;
		logic [31:0] p0;
		logic [31:0] p1;
	} parse_t;

	typedef struct packed {
		logic [31:0]            addr;
		logic [31:0]            remain;
		logic [31:0]            grp_addr;
		logic [31:0]            grp_remain;
		logic [`ISP_SUM_W-1:0]  sum;
		logic [4:0]             lines;
		logic [5:0]             left;
		logic [1:0]             bcnt;
		logic [1:0]             chidx;
		logic [23:0]            grp3;
	} xfer_t;

	typedef struct packed {
		logic [`ISP_SUM_W-1:0]  val;
		logic [2:0]             pos;
		logic [3:0]             dig;
		logic                   started;
	} dec_t;

endpackage : isp_pkg

// file: sim/isp_handler_assertions.sv
/* Port checker for the read and prepare command handler.
   Assumes a bind from the bench top onto every handler instance. */
`timescale 1ns/1ps
`include "isp_regs.svh"
module isp_handler_assertions #(
	parameter int               NSECT       = 8,
	parameter logic [31:0]      FLASH_BASE  = 32'h0000_0000,
	parameter logic [31:0]      FLASH_BYTES = 32'h0000_8000,
	parameter logic [31:0]      RAM_BASE    = 32'h1000_0000,
	parameter logic [31:0]      RAM_BYTES   = 32'h0000_2000,
	parameter logic [NSECT-1:0] BOOT_MASK   = {1'b1, {(NSECT-1){1'b0}}}
) (
	input wire logic              i_ref_clk,
	input wire logic              i_reset_n,
	input wire isp_pkg::byte_t    i_rx,
	input wire isp_pkg::byte_t    o_tx,
	input wire logic              i_tx_ready,
	input wire isp_pkg::mem_req_t o_mem,
	input wire logic [7:0]        i_mem_rdata,
	input wire logic              i_crp_active,
	input wire isp_pkg::op_req_t  i_op,
	input wire logic              i_op_done,
	input wire logic              o_op_permit,
	input wire logic [NSECT-1:0]  o_sector_prepared
);
	logic [NSECT-1:0] span;
	logic             lf_in;
	// ==========================================
	// Helpers
	always_comb begin
		for (int k = 0; k < NSECT; k++) begin
			span[k] = (k >= int'(i_op.first)) && (k <= int'(i_op.last));
		end
	end
	assign lf_in = i_rx.valid && (i_rx.data == `ISP_LF);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	// ==========================================
	// Properties
	property p_tx_hold;
		o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx.data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed before accept");
	property p_rd_space;
		o_mem.rd |=> !o_mem.rd;
	endproperty
	a_rd_space: assert property (p_rd_space) else $error("memory reads too close");
	property p_rd_map;
		o_mem.rd |-> (o_mem.addr - FLASH_BASE < FLASH_BYTES) || (o_mem.addr - RAM_BASE < RAM_BYTES);
	endproperty
	a_rd_map: assert property (p_rd_map) else $error("read outside memory");
	property p_tx_char;
		o_tx.valid |-> (o_tx.data inside {[8'h20:8'h5f], `ISP_CR, `ISP_LF});
	endproperty
	a_tx_char: assert property (p_tx_char) else $error("bad character sent");
	property p_boot;
		(o_sector_prepared & BOOT_MASK) == '0;
	endproperty
	a_boot: assert property (p_boot) else $error("boot sector unlocked");
	property p_permit;
		o_op_permit == (i_op.req && i_op.first <= i_op.last && int'(i_op.last) < NSECT
			&& (span & ~o_sector_prepared) == '0);
	endproperty
	a_permit: assert property (p_permit) else $error("permit wrong");
	property p_relock;
		i_op_done && !lf_in |=> (o_sector_prepared & $past(span)) == '0;
	endproperty
	a_relock: assert property (p_relock) else $error("sectors not relocked");
	property p_set_lf;
		|(o_sector_prepared & ~$past(o_sector_prepared)) |-> $past(lf_in);
	endproperty
	a_set_lf: assert property (p_set_lf) else $error("unlock without line end");
	c_read: cover property (o_mem.rd);
	c_stall: cover property (o_tx.valid && !i_tx_ready);
	c_relock: cover property (i_op_done && |o_sector_prepared);
endmodule : isp_handler_assertions

// file: sim/isp_host_model.sv
/* Host side of the command link: sends queued bytes, takes answer bytes.
   Assumes the bench fills out_q and empties in_q. */
`timescale 1ns/1ps
module isp_host_model (
	input  wire logic           i_ref_clk,
	input  wire isp_pkg::byte_t i_tx,
	output isp_pkg::byte_t      o_rx,
	output logic                o_ready
);
	logic [7:0] out_q[$];
	logic [7:0] in_q[$];
	initial begin
		o_rx = '0;
		o_ready = 1'b0;
	end
	// ==========================================
	// Byte pacing, random stalls on the answer side
	always @(posedge i_ref_clk) begin
		if (!o_rx.valid && out_q.size() > 0) begin
			o_rx <= {1'b1, out_q.pop_front()};
		end else begin
			o_rx <= {1'b0, ~o_rx.data};
		end
		if (o_ready && i_tx.valid) begin
			in_q.push_back(i_tx.data);
		end
		o_ready <= ($urandom % 4) != 0;
	end
endmodule : isp_host_model

// file: sim/tb.sv
/* Bench for the read and prepare handler with a byte-queue model.
   Assumes the host model and checker files compile first. */
`timescale 1ns/1ps
`include "isp_regs.svh"
module tb;
	logic              i_ref_clk = 1'b0;
	logic              i_reset_n = 1'b0;
	isp_pkg::byte_t    rx;
	isp_pkg::byte_t    tx;
	isp_pkg::mem_req_t mem;
	isp_pkg::op_req_t  op = '0;
	logic              ready, permit;
	logic              crp = 1'b0;
	logic              op_done = 1'b0;
	logic [7:0]        rdata;
	logic [7:0]        prep;
	logic [7:0]        pm = 8'h00;
	logic [7:0]        eq[$];
	int                err_total = 0;
	int                num_checks = 0;
	int                cyc = 0;
	int                sum;
	isp_read_prepare_handler dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_rx(rx),
		.o_tx(tx), .i_tx_ready(ready), .o_mem(mem), .i_mem_rdata(rdata), .i_crp_active(crp),
		.i_op(op), .i_op_done(op_done), .o_op_permit(permit), .o_sector_prepared(prep));
	isp_host_model host (.i_ref_clk(i_ref_clk), .i_tx(tx), .o_rx(rx), .o_ready(ready));
	// ==========================================
	// Clock, memory, hang limit
	always #12.5 i_ref_clk = ~i_ref_clk;
	function automatic logic [7:0] md(int a);
		return 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
	endfunction
	// Handler captures data on the edge that ends its read strobe, so answer at once
	assign rdata = md(mem.addr);
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			conclude();
		end
	end
	// ==========================================
	// Model and checks
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic void put_str(string s);
		for (int i = 0; i < s.len(); i++) eq.push_back(s[i]);
	endfunction
	task automatic drain;
		while (eq.size() > 0) begin
			while (host.in_q.size() == 0) @(posedge i_ref_clk);
			chk(host.in_q.pop_front(), eq.pop_front());
		end
	endtask
	task automatic ans(string s, int code);
		for (int i = 0; i < s.len(); i++) host.out_q.push_back(s[i]);
		host.out_q.push_back(`ISP_CR);
		host.out_q.push_back(`ISP_LF);
		if (code >= 0) put_str($sformatf("%0d\r\n", code));
		drain();
	endtask
	function automatic void uu(int b, int ln);
		logic [23:0] w;
		eq.push_back(8'(32 + ln));
		for (int j = 0; j < ln; j += 3) begin
			w = {md(b + j), (j + 1 < ln) ? md(b + j + 1) : 8'h00, (j + 2 < ln) ? md(b + j + 2) : 8'h00};
			for (int q = 3; q >= 0; q--) eq.push_back(8'h20 + 8'((w >> (6 * q)) & 24'h3f));
		end
		for (int j = 0; j < ln; j++) sum += md(b + j);
		put_str("\r\n");
	endfunction
	function automatic logic mapped(int a, int n);
		return (a + n <= 32'h8000) || (a >= 32'h1000_0000 && a + n <= 32'h1000_2000);
	endfunction
	task automatic rd(int a, int n, logic c, int rs);
		int   code, pos, st, ln, g;
		logic again;
		code = c ? 6 : (a % 4) ? 3 : (n % 4) ? 5 : !mapped(a, n) ? 4 : 0;
		crp <= c;
		@(posedge i_ref_clk);
		ans($sformatf("R %0d %0d", a, n), code);
		pos = 0;
		g = 0;
		while (code == 0 && pos < n) begin
			st = pos;
			again = 1'b0;
			do begin
				pos = st;
				sum = 0;
				for (int k = 0; k < 20 && pos < n; k++) begin
					ln = (n - pos > 45) ? 45 : n - pos;
					uu(a + pos, ln);
					pos += ln;
				end
				put_str($sformatf("%0d\r\n", sum));
				drain();
				again = (g == rs) && !again;
				ans(again ? "RESEND" : "OK", -1);
			end while (again);
			g++;
		end
		repeat (8) @(posedge i_ref_clk);
	endtask
	task automatic prp(int f, int l);
		ans($sformatf("P %0d %0d", f, l), (f > l || l >= 7) ? 1 : 0);
		if (f <= l && l < 7) for (int k = f; k <= l; k++) pm[k] = 1'b1;
		chk(prep, pm);
	endtask
	task automatic opc(int f, int l, logic done);
		logic pe;
		pe = (f <= l) && (l < 8);
		for (int k = f; k <= l && k < 8; k++) pe &= pm[k];
		op <= '{1'b1, 8'(f), 8'(l)};
		op_done <= done;
		@(posedge i_ref_clk);
		// Permit is read before the completion pulse has relocked anything
		chk(permit, pe);
		op_done <= 1'b0;
		if (done) for (int k = f; k <= l; k++) pm[k] = 1'b0;
		@(posedge i_ref_clk);
		chk(prep, pm);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// Scenarios
	initial begin
		void'($urandom(94320));
		repeat (6) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		@(posedge i_ref_clk);
		rd(32'h1000_0000, 4, 1'b0, -1);
		rd(32'h1000_0002, 8, 1'b1, -1);
		rd(32'h1000_0002, 8, 1'b0, -1);
		rd(32'h1000_0000, 6, 1'b0, -1);
		rd(32'h0000_7ffc, 8, 1'b0, -1);
		rd(32'h2000_0000, 4, 1'b0, -1);
		rd(0, 0, 1'b0, -1);
		rd(32'h1000_0000 + ($urandom % 1500) * 4, 920, 1'b0, 0);
		rd(($urandom % 100) * 4, 48, 1'b0, 1);
		ans("R 4", 2);
		ans("P 1 x", 2);
		ans("X 1 2", -1);
		prp(2, 4);
		prp(5, 5);
		prp(4, 3);
		prp(6, 7);
		prp(3, 8);
		opc(2, 4, 1'b0);
		opc(5, 4, 1'b0);
		opc(1, 5, 1'b0);
		opc(2, 3, 1'b1);
		opc(2, 4, 1'b0);
		prp($urandom % 7, 6);
		opc(4, 6, 1'b1);
		conclude();
	end
endmodule : tb
bind isp_read_prepare_handler isp_handler_assertions #(.NSECT(NSECT),
	.FLASH_BASE(FLASH_BASE), .FLASH_BYTES(FLASH_BYTES), .RAM_BASE(RAM_BASE),
	.RAM_BYTES(RAM_BYTES), .BOOT_MASK(BOOT_MASK)) sva (.i_ref_clk(i_ref_clk),
	.i_reset_n(i_reset_n), .i_rx(i_rx), .o_tx(o_tx), .i_tx_ready(i_tx_ready), .o_mem(o_mem),
	.i_mem_rdata(i_mem_rdata), .i_crp_active(i_crp_active), .i_op(i_op),
	.i_op_done(i_op_done), .o_op_permit(o_op_permit), .o_sector_prepared(o_sector_prepared));
